// *** design/pfs_pkg.sv ***
// package of constants and types for the parallel flash command host
// assumes a 40 MHz pclk and an 8-bit, 256K-location NOR flash on the pins

package pfs_pkg;

    // ********************************************************
    // clock and pin timing
    // ********************************************************
    localparam int CLK_MHZ = 40;
    localparam int T_WE_PULSE_NS = 45;
    localparam int T_READ_ACCESS_NS = 120;
    localparam int T_STROBE_RECOVER_NS = 20;
    localparam int T_RESET_PULSE_NS = 500;
    localparam int T_RESET_RECOVER_NS = 50;

    // least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [3:0] WE_PULSE_CYC = 4'(ns_to_cyc(T_WE_PULSE_NS));
    localparam logic [3:0] READ_ACCESS_CYC = 4'(ns_to_cyc(T_READ_ACCESS_NS));
    localparam logic [3:0] RECOVER_CYC = 4'(ns_to_cyc(T_STROBE_RECOVER_NS));
    localparam logic [7:0] RST_RECOVER_CYC = 8'(ns_to_cyc(T_RESET_RECOVER_NS));
    localparam logic [7:0] RST_TOTAL_CYC =
        8'(ns_to_cyc(T_RESET_PULSE_NS) + ns_to_cyc(T_RESET_RECOVER_NS));
    localparam logic [3:0] CNT_ONE = 4'h1;

    // ********************************************************
    // flash side types and command codes
    // ********************************************************
    typedef logic [17:0] pfs_addr_t;
    typedef logic [7:0] pfs_byte_t;

    localparam pfs_addr_t UNLOCK_ADDR1 = 18'h00555;
    localparam pfs_addr_t UNLOCK_ADDR2 = 18'h002AA;
    localparam pfs_addr_t PROT_ADDR_BASE = 18'h00200;
    localparam pfs_addr_t PROT_SEL_MASK = 18'h00040;
    localparam pfs_addr_t PROT_VERIFY_ADDR = 18'h00202;

    localparam pfs_byte_t FC_UNLOCK1 = 8'hAA;
    localparam pfs_byte_t FC_UNLOCK2 = 8'h55;
    localparam pfs_byte_t FC_PROGRAM = 8'hA0;
    localparam pfs_byte_t FC_ERASE_SETUP = 8'h80;
    localparam pfs_byte_t FC_CHIP_ERASE = 8'h10;
    localparam pfs_byte_t FC_SECTOR_ERASE = 8'h30;
    localparam pfs_byte_t FC_SUSPEND = 8'hB0;
    localparam pfs_byte_t FC_RESUME = 8'h30;
    localparam pfs_byte_t FC_READ_ID = 8'h90;
    localparam pfs_byte_t FC_PROT_UNLOCK = 8'h20;
    localparam pfs_byte_t FC_PROT_WRITE = 8'h00;
    localparam pfs_byte_t FC_RESET = 8'hF0;

    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int FAIL_BIT = 5;
    localparam int PROTECTED_BIT = 0;

    // ********************************************************
    // command sequence steps and lengths
    // ********************************************************
    localparam logic [2:0] STEP_UNLOCK2 = 3'h1;
    localparam logic [2:0] STEP_SETUP = 3'h2;
    localparam logic [2:0] STEP_TARGET = 3'h3;
    localparam logic [2:0] STEP_UNLOCK4 = 3'h4;
    localparam logic [2:0] STEP_FINAL = 3'h5;
    localparam logic [2:0] STEP_PROTECT = 3'h6;
    localparam logic [2:0] LEN_NONE = 3'h0;
    localparam logic [2:0] LEN_SINGLE = 3'h1;
    localparam logic [2:0] LEN_ID = 3'h3;
    localparam logic [2:0] LEN_PROGRAM = 3'h4;
    localparam logic [2:0] LEN_ERASE = 3'h6;
    localparam logic [2:0] LEN_PROTECT = 3'h7;

    typedef enum logic [3:0] {
        CMD_READ, CMD_RESET, CMD_PROGRAM, CMD_CHIP_ERASE, CMD_SECTOR_ERASE,
        CMD_SUSPEND, CMD_RESUME, CMD_READ_ID, CMD_PROTECT, CMD_HW_RESET
    } pfs_cmd_t;

    // ********************************************************
    // apb register map
    // ********************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_CMD_MSB = 3;
    localparam int CTRL_PROT_SEL = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_FAIL = 1;
    localparam int ST_DONE = 2;
    localparam int ST_PROTECTED = 3;
    localparam int ST_POLLING = 4;

endpackage

// *** design/pfs_pin_cycle.sv ***
// one flash bus cycle (write or read) on the chip pins
// assumes the flash data input is synchronous to pclk

`timescale 1ns/1ps

module pfs_pin_cycle
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic wr,
    input wire pfs_pkg::pfs_addr_t addr_in,
    input wire pfs_pkg::pfs_byte_t wdata_in,
    output logic done,
    output pfs_pkg::pfs_byte_t rdata,
    output pfs_pkg::pfs_addr_t flash_addr,
    input wire pfs_pkg::pfs_byte_t flash_dq_i,
    output pfs_pkg::pfs_byte_t flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    import pfs_pkg::*;

    typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} pfs_phase_t;

    pfs_phase_t phase_q;
    logic [3:0] cnt_q;
    logic wr_q;

    wire last = (cnt_q == CNT_ONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= P_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            flash_addr <= 18'h00000;
            flash_dq_o <= 8'h00;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (phase_q)
                P_IDLE: begin
                    if (start) begin
                        // write: select low, output enable high
                        flash_addr <= addr_in;
                        flash_dq_o <= wdata_in;
                        flash_dq_oe <= wr; // never drive during a read
                        flash_ce_n <= 1'b0;
                        wr_q <= wr;
                        phase_q <= P_SETUP;
                    end
                end
                P_SETUP: begin
                    // address stable a cycle before the strobe falls
                    flash_we_n <= ~wr_q;
                    flash_oe_n <= wr_q;
                    cnt_q <= wr_q ? WE_PULSE_CYC : READ_ACCESS_CYC;
                    phase_q <= P_STROBE;
                end
                P_STROBE: begin
                    if (last) begin
                        // data stays driven across the rising strobe
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        if (!wr_q) begin
                            rdata <= flash_dq_i;
                        end
                        cnt_q <= RECOVER_CYC;
                        phase_q <= P_HOLD;
                    end else begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                default: begin
                    if (last) begin
                        flash_ce_n <= 1'b1;
                        flash_dq_oe <= 1'b0;
                        done <= 1'b1;
                        phase_q <= P_IDLE;
                    end else begin
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
            endcase
        end
    end

endmodule

// *** design/pfs_flash_host.sv ***
// host controller for a parallel NOR flash command interface, APB slave
// assumes one flash on the pins, data input synchronous to pclk

`timescale 1ns/1ps

module pfs_flash_host
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output pfs_pkg::pfs_addr_t address_pins,
    input wire pfs_pkg::pfs_byte_t data_pins_i,
    output pfs_pkg::pfs_byte_t data_pins_o,
    output logic data_pins_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n
);
    import pfs_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_WR, S_WR_WAIT, S_RD, S_RD_WAIT, S_HWRST
    } pfs_state_t;

    // ********************************************************
    // registers
    // ********************************************************
    pfs_state_t state_q;
    pfs_cmd_t op_q;
    logic [2:0] step_q;
    pfs_addr_t addr_q;
    pfs_byte_t wdata_q;
    pfs_byte_t rdata_q;
    pfs_byte_t prev_q;
    logic prot_sel_q;
    logic fail_q;
    logic done_q;
    logic protected_q;
    logic polling_q;
    logic have_prev_q;
    logic fail_seen_q;
    logic susp_pend_q;
    logic [7:0] rst_cnt_q;
    logic eng_start_q;
    logic eng_wr_q;
    pfs_addr_t eng_addr_q;
    pfs_byte_t eng_wdata_q;
    logic eng_done;
    pfs_byte_t eng_rdata;

    // ********************************************************
    // apb decode
    // ********************************************************
    wire idle = (state_q == S_IDLE);
    wire apb_setup = psel & ~penable;
    wire apb_commit = psel & penable & pready;
    wire hit_ctrl = (paddr == REG_CTRL);
    wire hit_addr = (paddr == REG_ADDR);
    wire hit_wdata = (paddr == REG_WDATA);
    wire hit_status = (paddr == REG_STATUS);
    wire hit_rdata = (paddr == REG_RDATA);
    wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_status | hit_rdata;
    wire wr_ctrl = apb_commit & pwrite & hit_ctrl;
    wire [3:0] cmd_field = pwdata[CTRL_CMD_MSB:CTRL_CMD_LSB];
    wire cmd_legal = (cmd_field <= CMD_HW_RESET);
    pfs_cmd_t new_cmd;
    assign new_cmd = pfs_cmd_t'(cmd_field);
    // busy refuses all but a suspend of a polled sector erase, so no write lands mid program
    wire start_cmd = wr_ctrl & idle & cmd_legal;
    // only suspend gets through while a sector erase is polled
    wire suspend_req = wr_ctrl & ~idle & polling_q
        & (new_cmd == CMD_SUSPEND) & (op_q == CMD_SECTOR_ERASE);

    wire [31:0] status_word = {27'h0000000, polling_q, protected_q,
        done_q, fail_q, ~idle};
    wire [31:0] rd_word =
        hit_ctrl ? {27'h0000000, prot_sel_q, op_q} :
        hit_addr ? {14'h0000, addr_q} :
        hit_wdata ? {24'h000000, wdata_q} :
        hit_status ? status_word :
        hit_rdata ? {24'h000000, rdata_q} : 32'h00000000;

    // answer in the first access cycle, registered so outputs are flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~mapped;
            prdata <= (apb_setup & ~pwrite) ? rd_word : 32'h00000000;
        end
    end

    // operands stay frozen while a command runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 18'h00000;
            wdata_q <= 8'h00;
        end else if (apb_commit & pwrite & idle) begin
            if (hit_addr) begin
                addr_q <= pwdata[17:0];
            end else if (hit_wdata) begin
                wdata_q <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_pend_q <= 1'b0;
        end else if (suspend_req) begin
            susp_pend_q <= 1'b1;
        end else if (idle) begin
            susp_pend_q <= 1'b0;
        end
    end

    // ********************************************************
    // command sequence table
    // ********************************************************
    function automatic logic [2:0] seq_len(input pfs_cmd_t c);
        case (c)
            CMD_RESET, CMD_SUSPEND, CMD_RESUME: return LEN_SINGLE;
            CMD_READ_ID: return LEN_ID;
            CMD_PROGRAM: return LEN_PROGRAM;
            CMD_CHIP_ERASE, CMD_SECTOR_ERASE: return LEN_ERASE;
            CMD_PROTECT: return LEN_PROTECT;
            default: return LEN_NONE;
        endcase
    endfunction

    // unlock cycles use only the low lines; the rest stay zero
    function automatic logic [25:0] seq_cycle(input pfs_cmd_t c,
        input logic [2:0] s, input pfs_addr_t a, input pfs_byte_t d,
        input logic ps);
        pfs_addr_t pa;
        pfs_byte_t code;
        pa = UNLOCK_ADDR1;
        code = FC_UNLOCK1;
        if (c == CMD_RESET || c == CMD_SUSPEND || c == CMD_RESUME) begin
            pa = a; // any address will do
            code = (c == CMD_RESET) ? FC_RESET :
                (c == CMD_SUSPEND) ? FC_SUSPEND : FC_RESUME;
        end else if (s == STEP_UNLOCK2 || s == STEP_UNLOCK4) begin
            pa = UNLOCK_ADDR2;
            code = FC_UNLOCK2;
        end else if (s == STEP_TARGET && c == CMD_PROGRAM) begin
            pa = a; // target address and byte
            code = d;
        end else if (s == STEP_SETUP) begin
            code = (c == CMD_PROGRAM) ? FC_PROGRAM :
                (c == CMD_READ_ID) ? FC_READ_ID : FC_ERASE_SETUP;
        end else if (s == STEP_FINAL) begin
            code = (c == CMD_CHIP_ERASE) ? FC_CHIP_ERASE :
                (c == CMD_SECTOR_ERASE) ? FC_SECTOR_ERASE :
                FC_PROT_UNLOCK;
            if (c == CMD_SECTOR_ERASE) begin
                pa = a;
            end
        end else if (s == STEP_PROTECT) begin
            pa = PROT_ADDR_BASE | (ps ? PROT_SEL_MASK : 18'h00000);
            code = FC_PROT_WRITE;
        end
        return {pa, code};
    endfunction

    wire [25:0] cyc = seq_cycle(op_q, step_q, addr_q, wdata_q, prot_sel_q);
    wire [2:0] len = seq_len(op_q);
    wire more_steps = ((step_q + 3'h1) < len);
    wire poll_op = (op_q == CMD_PROGRAM) | (op_q == CMD_CHIP_ERASE)
        | (op_q == CMD_SECTOR_ERASE) | (op_q == CMD_RESUME);

    // ********************************************************
    // status polling decisions
    // ********************************************************
    wire tog_same = (eng_rdata[TOGGLE_BIT] == prev_q[TOGGLE_BIT]);
    wire settled = have_prev_q & tog_same;
    // program ends with true data; erase ends with the poll bit high
    wire end_bad = (op_q == CMD_PROGRAM) ? (eng_rdata != wdata_q) :
        ~eng_rdata[POLL_BIT];
    // fail bit seen on two toggling reads in a row
    wire timed_out = have_prev_q & eng_rdata[FAIL_BIT] & fail_seen_q;

    // ********************************************************
    // sequencer
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            op_q <= CMD_READ;
            step_q <= 3'h0;
            prot_sel_q <= 1'b0;
            fail_q <= 1'b0;
            done_q <= 1'b0;
            protected_q <= 1'b0;
            polling_q <= 1'b0;
            have_prev_q <= 1'b0;
            fail_seen_q <= 1'b0;
            prev_q <= 8'h00;
            rdata_q <= 8'h00;
            rst_cnt_q <= 8'h00;
            flash_reset_n <= 1'b1;
            eng_start_q <= 1'b0;
            eng_wr_q <= 1'b0;
            eng_addr_q <= 18'h00000;
            eng_wdata_q <= 8'h00;
        end else begin
            eng_start_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start_cmd) begin
                        op_q <= new_cmd;
                        prot_sel_q <= pwdata[CTRL_PROT_SEL];
                        step_q <= 3'h0;
                        fail_q <= 1'b0;
                        done_q <= 1'b0;
                        have_prev_q <= 1'b0;
                        fail_seen_q <= 1'b0;
                        if (new_cmd == CMD_HW_RESET) begin
                            rst_cnt_q <= RST_TOTAL_CYC;
                            flash_reset_n <= 1'b0;
                            state_q <= S_HWRST;
                        end else if (new_cmd == CMD_READ) begin
                            eng_addr_q <= addr_q;
                            state_q <= S_RD;
                        end else begin
                            state_q <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    eng_start_q <= 1'b1;
                    eng_wr_q <= 1'b1;
                    eng_addr_q <= cyc[25:8];
                    eng_wdata_q <= cyc[7:0];
                    state_q <= S_WR_WAIT;
                end
                S_WR_WAIT: begin
                    if (eng_done) begin
                        if (more_steps) begin
                            step_q <= step_q + 3'h1;
                            state_q <= S_WR;
                        end else if (poll_op) begin
                            // single sector only, no 30us reload window
                            // device runs the algorithm unaided
                            polling_q <= 1'b1;
                            eng_addr_q <= addr_q;
                            state_q <= S_RD;
                        end else if (op_q == CMD_PROTECT) begin
                            eng_addr_q <= PROT_VERIFY_ADDR;
                            state_q <= S_RD;
                        end else begin
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_RD: begin
                    eng_start_q <= 1'b1;
                    eng_wr_q <= 1'b0;
                    state_q <= S_RD_WAIT;
                end
                S_RD_WAIT: begin
                    if (eng_done) begin
                        rdata_q <= eng_rdata;
                        if (!polling_q) begin
                            if (op_q == CMD_PROTECT) begin
                                protected_q <= eng_rdata[PROTECTED_BIT];
                            end
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (susp_pend_q) begin
                            // erase stays suspended; device in read mode
                            polling_q <= 1'b0;
                            op_q <= CMD_SUSPEND;
                            step_q <= 3'h0;
                            state_q <= S_WR;
                        end else if (settled && !end_bad) begin
                            polling_q <= 1'b0;
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (settled || timed_out) begin
                            // abort the failed operation back to read
                            polling_q <= 1'b0;
                            fail_q <= 1'b1;
                            op_q <= CMD_RESET;
                            step_q <= 3'h0;
                            state_q <= S_WR;
                        end else begin
                            fail_seen_q <= have_prev_q & eng_rdata[FAIL_BIT];
                            prev_q <= eng_rdata;
                            have_prev_q <= 1'b1;
                            state_q <= S_RD;
                        end
                    end
                end
                default: begin
                    // low for the pulse, then high through recovery
                    rst_cnt_q <= rst_cnt_q - 8'h01;
                    flash_reset_n <= (rst_cnt_q <= RST_RECOVER_CYC + 8'h01);
                    if (rst_cnt_q == 8'h01) begin
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    pfs_pin_cycle u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .start(eng_start_q),
        .wr(eng_wr_q),
        .addr_in(eng_addr_q),
        .wdata_in(eng_wdata_q),
        .done(eng_done),
        .rdata(eng_rdata),
        .flash_addr(address_pins),
        .flash_dq_i(data_pins_i),
        .flash_dq_o(data_pins_o),
        .flash_dq_oe(data_pins_oe),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n)
    );

endmodule

// *** tb/pfs_chk_sva.sv ***
// pin and apb timing checks for the flash host
// assumes bind onto pfs_flash_host
`timescale 1ns/1ps
module pfs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic data_pins_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence we_pulse;
        !flash_we_n ##1 !flash_we_n ##1 flash_we_n;
    endsequence
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held");
    we_width_a: assert property ($fell(flash_we_n) |-> we_pulse)
        else $error("write strobe width");
    oe_width_a: assert property ($fell(flash_oe_n) |->
        !flash_oe_n[*5] ##1 flash_oe_n) else $error("read strobe width");
    write_qual_a: assert property (!flash_we_n |->
        !flash_ce_n && flash_oe_n && data_pins_oe) else $error("bad write");
    read_qual_a: assert property (!flash_oe_n |->
        !flash_ce_n && flash_we_n && !data_pins_oe) else $error("bad read");
    ce_gap_a: assert property ($rose(flash_ce_n) |-> flash_ce_n[*2])
        else $error("select gap short");
    reset_pulse_a: assert property ($fell(flash_reset_n) |->
        !flash_reset_n[*8]) else $error("reset pulse short");
endmodule
bind pfs_flash_host pfs_chk i_chk (.pclk, .presetn, .psel, .penable,
    .pready, .data_pins_oe, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_reset_n);

// *** tb/pfs_flash_model.sv ***
// behavioural flash: byte program and status polling only
// assumes host pins change just after pclk edges
`timescale 1ns/1ps
module pfs_flash_model (
    input wire logic pclk,
    input wire pfs_pkg::pfs_addr_t addr,
    input wire pfs_pkg::pfs_byte_t din,
    output pfs_pkg::pfs_byte_t dout = 8'h00,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n
);
    import pfs_pkg::*;
    pfs_byte_t mem = 8'hFF;
    pfs_addr_t a, pa;
    logic [1:0] n = 2'h0;
    logic we_q = 1'b1, oe_q = 1'b1, tog = 1'b0;
    int busy = 0;
    always @(posedge pclk) begin
        we_q <= we_n;
        oe_q <= oe_n;
        if (!rst_n) begin
            n <= 2'h0;
        end else if (!ce_n && !we_n && we_q) begin
            a <= addr;
        end else if (!ce_n && we_n && !we_q) begin
            n <= 2'h0;
            if (busy > 0) n <= 2'h0;
            else if (din == 8'hAA && a[10:0] == 11'h555) n <= 2'h1;
            else if (n == 2'h1 && din == 8'h55 && a[10:0] == 11'h2AA) n <= 2'h2;
            else if (n == 2'h2 && din == 8'hA0 && a[10:0] == 11'h555) n <= 2'h3;
            else if (n == 2'h3) begin
                mem <= din;
                pa <= a;
                busy <= 3;
            end
        end
        if (!ce_n && !oe_n && oe_q && busy > 0) begin
            busy <= busy - 1;
            tog <= !tog;
        end
        // a released bus inverts its last value every cycle, never holding it
        dout <= (!ce_n && !oe_n) ? (busy > 0 ? {~mem[7], tog, 6'h00} : mem)
            : ~dout;
    end
endmodule

// *** tb/testbench.sv ***
// self-checking bench: program, refusal, unmapped access, pin reset
// assumes pfs_flash_host with the flash model on its pins
`timescale 1ns/1ps
module testbench;
    import pfs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, dq_oe, ce_n, oe_n, we_n, rst_n;
    pfs_addr_t fa;
    pfs_byte_t dq_i, dq_o;
    int num_errors = 0, n_tests = 0;
    initial forever #12.5 pclk = ~pclk;
    pfs_flash_host i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .address_pins(fa),
        .data_pins_i(dq_i), .data_pins_o(dq_o), .data_pins_oe(dq_oe),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_reset_n(rst_n));
    pfs_flash_model i_flash (.pclk, .addr(fa), .din(dq_o), .dout(dq_i),
        .ce_n, .oe_n, .we_n, .rst_n);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 20) begin
            num_errors++;
            report_and_stop;
        end
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 300; i++) begin
            apb(0, REG_STATUS, 32'h0);
            if (rd[ST_BUSY] === 1'b0) break;
        end
        check(32'(i < 300), 32'h1);
        if (i >= 300) report_and_stop;
    endtask
    task automatic t_program;
        apb(1, REG_ADDR, 32'h31234);
        apb(1, REG_WDATA, 32'h5A);
        apb(1, REG_CTRL, 32'h2);
        // a new byte written mid-program must not reach the flash
        apb(1, REG_WDATA, 32'hC3);
        wait_idle;
        check(rd & 32'h7, 32'h4);
        check(32'(i_flash.mem), 32'h5A);
        check(32'(i_flash.pa), 32'h31234);
        apb(0, REG_RDATA, 32'h0);
        check(rd, 32'h5A);
        $display("program test over");
    endtask
    task automatic t_erase_fail;
        // the model never erases, so the poll bit stays low: host aborts
        apb(1, REG_CTRL, 32'h3);
        wait_idle;
        check(rd & 32'h7, 32'h6);
        check(32'(dq_o), 32'hF0);
        $display("erase fail test over");
    endtask
    task automatic t_protect;
        apb(1, REG_CTRL, 32'h18);
        wait_idle;
        check(rd & 32'h7, 32'h4);
        check(32'({i_flash.a[9], i_flash.a[6]}), 32'h3);
        check(32'(fa[7:0]), 32'h02);
        $display("protect test over");
    endtask
    task automatic t_read_reset;
        apb(1, REG_CTRL, 32'h0);
        wait_idle;
        apb(0, REG_RDATA, 32'h0);
        check(rd, 32'h5A);
        apb(1, REG_CTRL, 32'h1);
        wait_idle;
        check(rd & 32'h7, 32'h4);
        check(32'(dq_o), 32'hF0);
        $display("read and reset test over");
    endtask
    task automatic t_unmapped;
        apb(0, 8'h40, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        $display("unmapped test over");
    endtask
    task automatic t_pin_reset;
        apb(1, REG_CTRL, 32'h9);
        wait_idle;
        check(rd & 32'h7, 32'h4);
        $display("pin reset test over");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_program;
        t_erase_fail;
        t_protect;
        t_read_reset;
        t_unmapped;
        t_pin_reset;
        report_and_stop;
    end
endmodule
